// ### uep_defs.svh
// Register offsets, field positions, reset values and limits for the endpoint-zero block.
// Included by the design, the checker and the testbench; holds definitions only.
`ifndef UEP_DEFS_SVH
`define UEP_DEFS_SVH
// Register indices, and APB byte addresses (index times four)
`define UEP_IDX_OUT_IE      8'h09
`define UEP_IDX_CM_IE       8'h0b
`define UEP_IDX_INDEX       8'h0e
`define UEP_IDX_E0CTL       8'h11
`define UEP_IDX_EP_ZERO_BYTE_COUNT       8'h16
`define UEP_IDX_EVT         8'h20
`define UEP_ADDR_OUT_IE     12'h024
`define UEP_ADDR_CM_IE      12'h02c
`define UEP_ADDR_INDEX      12'h038
`define UEP_ADDR_E0CTL      12'h044
`define UEP_ADDR_EP_ZERO_BYTE_COUNT      12'h058
`define UEP_ADDR_EVT        12'h080
// Reset values and write masks
`define UEP_OUT_IE_RST      8'h0e
`define UEP_CM_IE_RST       8'h06
`define UEP_OUT_IE_MASK     8'h0e
`define UEP_CM_IE_MASK      8'h0f
// Common enable bits
`define UEP_CM_SOF          3
`define UEP_CM_RST          2
`define UEP_CM_RSU          1
`define UEP_CM_SUS          0
// Endpoint-zero control bits
`define UEP_E0_RXRDY        0
`define UEP_E0_TXRDY        1
`define UEP_E0_SENT_STALL_FLAG        2
`define UEP_E0_DEND         3
`define UEP_E0_SETUP_END_FLAG        4
`define UEP_E0_SEND_STALL_BIT        5
`define UEP_E0_SRX          6
`define UEP_E0_SERVICED_SETUP_END       7
// Setup payload length in bytes
`define UEP_SETUP_LEN       7'd8
`endif

// ### uep_pkg.sv
// Types shared by the endpoint-zero block.
// Assumes uep_defs.svh is on the include path.
package uep_pkg;
    // Token kinds delivered by the packet front end
    typedef enum logic [1:0] {
        UEP_TOK_OUT,
        UEP_TOK_IN,
        UEP_TOK_SETUP,
        UEP_TOK_SOF
    } uep_tok_t;

    // Handshakes the block asks the transmitter to send
    typedef enum logic [1:0] {
        UEP_HS_NONE,
        UEP_HS_ACK,
        UEP_HS_NAK,
        UEP_HS_STALL
    } uep_hs_t;

    // Token strobe with its kind and target endpoint
    typedef struct packed {
        logic       valid;
        uep_tok_t   kind;
        logic [3:0] ep;
    } uep_token_t;

    // End of a received data packet
    typedef struct packed {
        logic       valid;
        logic       crc_ok;
        logic       data1;
        logic [6:0] len;
    } uep_rxdone_t;

    // Bus-level events seen by the line monitor
    typedef struct packed {
        logic sof;
        logic bus_reset;
        logic resume;
        logic suspend;
    } uep_busev_t;
endpackage : uep_pkg

// ### uep_ctl.sv
// Endpoint-zero control, handshake choice and interrupt enables behind an APB slave.
// Assumes a packet front end that decodes tokens, checks CRC and reports lengths,
// and that the FIFO data path lives elsewhere; all inputs synchronous to pclk.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`include "uep_defs.svh"

module uep_ctl #(
    parameter int MAX_PKT = 64
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire uep_pkg::uep_token_t  token,
    input  wire uep_pkg::uep_rxdone_t rx_done,
    input  wire logic                 tx_ack,
    input  wire uep_pkg::uep_busev_t  bus_ev,
    input  wire logic [3:1]           out_ep_event,
    output uep_pkg::uep_hs_t          handshake,
    output logic                      handshake_valid,
    output logic                      usb_irq
);
    import uep_pkg::*;

    typedef enum {
        ST_IDLE,
        ST_SETUP_RX,
        ST_TX_MODE,
        ST_RX_MODE,
        ST_OUT_RX,
        ST_IN_STATUS
    } uep_state_t;

    uep_state_t  state_r;
    logic [7:0]  out_ie_r;
    logic [7:0]  cm_ie_r;
    logic [3:0]  index_r;
    logic        rxrdy_r;
    logic        txrdy_r;
    logic        sent_stall_flag_r;
    logic        dend_r;
    logic        setup_end_flag_r;
    logic [6:0]  cnt_r;
    logic        ep0_ev_r;
    logic [3:0]  cm_ev_r;
    logic [3:1]  out_ev_r;

    logic        wr_en;
    logic        rd_en;
    logic        e0_sel;
    logic        tok_ep0;
    logic        wr_ctl;
    logic        stall_now;
    logic        set_stall;
    logic        set_setup_end_flag;
    logic        set_rxrdy;
    logic        clr_txrdy;
    logic        ep0_fire;
    logic        ev_clr;
    logic [7:0]  ev_wmask;

    // Zero wait-state slave
    assign wr_en   = psel && penable && pwrite && pready;
    assign rd_en   = psel && !penable;
    assign e0_sel  = (index_r == 4'h0);
    assign wr_ctl  = wr_en && (paddr == `UEP_ADDR_E0CTL) && e0_sel;
    assign tok_ep0 = token.valid && (token.ep == 4'h0);
    assign ev_clr  = wr_en && (paddr == `UEP_ADDR_EVT);
    assign ev_wmask = pwdata[7:0];

    // Bad-CRC packets are invisible: no flag, no count, no event
    always_comb begin
        stall_now = 1'b0;
        set_setup_end_flag = 1'b0;
        set_rxrdy = 1'b0;
        clr_txrdy = 1'b0;
        ep0_fire  = 1'b0;
        if (wr_ctl && pwdata[`UEP_E0_SEND_STALL_BIT]) begin
            stall_now = 1'b1;
        end
        if (tok_ep0) begin
            case (state_r)
                ST_TX_MODE: begin
                    if (token.kind == UEP_TOK_IN && dend_r && !txrdy_r) begin
                        stall_now = 1'b1;
                    end else if (token.kind == UEP_TOK_SETUP ||
                                 token.kind == UEP_TOK_OUT) begin
                        set_setup_end_flag = !dend_r;
                    end
                end
                ST_RX_MODE: begin
                    if (token.kind == UEP_TOK_OUT && dend_r) begin
                        stall_now = 1'b1;
                    end else if (token.kind == UEP_TOK_SETUP ||
                                 token.kind == UEP_TOK_IN) begin
                        set_setup_end_flag = !dend_r;
                    end
                end
                default: begin
                end
            endcase
        end
        if (rx_done.valid && rx_done.crc_ok) begin
            if (rx_done.len > 7'(MAX_PKT)) begin
                stall_now = 1'b1;
            end else if (state_r == ST_SETUP_RX) begin
                set_rxrdy = (rx_done.len == `UEP_SETUP_LEN);
            end else if (state_r == ST_IN_STATUS) begin
                if (rx_done.data1 && rx_done.len != 7'd0) begin
                    stall_now = 1'b1;
                end else begin
                    ep0_fire = 1'b1;
                end
            end else if (state_r == ST_OUT_RX) begin
                set_rxrdy = 1'b1;
            end
        end
        if (tx_ack && state_r == ST_TX_MODE && txrdy_r) begin
            clr_txrdy = 1'b1;
        end
        set_stall = stall_now;
    end

    // Control transfer sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else if (set_stall || bus_ev.bus_reset) begin
            state_r <= ST_IDLE;
        end else if (tok_ep0 && token.kind == UEP_TOK_SETUP) begin
            state_r <= ST_SETUP_RX;
        end else if (tok_ep0 && token.kind == UEP_TOK_IN) begin
            if (state_r == ST_RX_MODE || state_r == ST_IDLE) begin
                state_r <= (state_r == ST_RX_MODE) ? ST_IDLE : ST_TX_MODE;
            end else if (state_r == ST_SETUP_RX) begin
                state_r <= ST_TX_MODE;
            end
        end else if (tok_ep0 && token.kind == UEP_TOK_OUT) begin
            if (state_r == ST_TX_MODE && dend_r) begin
                state_r <= ST_IN_STATUS;
            end else if (state_r == ST_SETUP_RX || state_r == ST_RX_MODE) begin
                state_r <= ST_OUT_RX;
            end
        end else if (rx_done.valid && rx_done.crc_ok) begin
            case (state_r)
                ST_SETUP_RX: state_r <= set_rxrdy ? ST_SETUP_RX : ST_IDLE;
                ST_OUT_RX: state_r <= ST_RX_MODE;
                ST_IN_STATUS: state_r <= ST_IDLE;
                default: state_r <= state_r;
            endcase
        end
    end

    // Handshake answer to tokens and packets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            handshake       <= UEP_HS_NONE;
            handshake_valid <= 1'b0;
        end else begin
            handshake_valid <= 1'b0;
            handshake       <= UEP_HS_NONE;
            if (set_stall && !(wr_ctl && pwdata[`UEP_E0_SEND_STALL_BIT] && !tok_ep0
                               && !rx_done.valid)) begin
                handshake       <= UEP_HS_STALL;
                handshake_valid <= 1'b1;
            end else if (tok_ep0 && token.kind == UEP_TOK_IN && !txrdy_r) begin
                handshake       <= UEP_HS_NAK;
                handshake_valid <= 1'b1;
            end else if (set_rxrdy || ep0_fire) begin
                handshake       <= UEP_HS_ACK;
                handshake_valid <= 1'b1;
            end
        end
    end

    // Endpoint-zero flags; hardware set or clear wins over a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxrdy_r <= 1'b0;
            txrdy_r <= 1'b0;
            sent_stall_flag_r <= 1'b0;
            dend_r  <= 1'b0;
            setup_end_flag_r <= 1'b0;
        end else begin
            if (set_rxrdy) begin
                rxrdy_r <= 1'b1;
            end else if (wr_ctl && pwdata[`UEP_E0_SRX]) begin
                rxrdy_r <= 1'b0;
            end
            if (clr_txrdy || set_stall) begin
                txrdy_r <= 1'b0;
            end else if (wr_ctl && pwdata[`UEP_E0_TXRDY]) begin
                txrdy_r <= 1'b1;
            end
            if (set_stall) begin
                sent_stall_flag_r <= 1'b1;
            end else if (wr_ctl && !pwdata[`UEP_E0_SENT_STALL_FLAG]) begin
                sent_stall_flag_r <= 1'b0;
            end
            if (set_setup_end_flag) begin
                setup_end_flag_r <= 1'b1;
            end else if (wr_ctl && pwdata[`UEP_E0_SERVICED_SETUP_END]) begin
                setup_end_flag_r <= 1'b0;
            end
            if (tok_ep0 && token.kind == UEP_TOK_SETUP || set_stall) begin
                dend_r <= 1'b0;
            end else if (wr_ctl && pwdata[`UEP_E0_DEND]) begin
                dend_r <= 1'b1;
            end
        end
    end

    // Received byte count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 7'd0;
        end else if (set_rxrdy) begin
            cnt_r <= rx_done.len;
        end else if (wr_ctl && pwdata[`UEP_E0_SRX]) begin
            cnt_r <= 7'd0;
        end
    end

    // Sticky events; set wins, write-one clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ep0_ev_r <= 1'b0;
            cm_ev_r  <= 4'h0;
        end else begin
            if (set_rxrdy || clr_txrdy || ep0_fire || set_stall || set_setup_end_flag) begin
                ep0_ev_r <= 1'b1;
            end else if (ev_clr && ev_wmask[4]) begin
                ep0_ev_r <= 1'b0;
            end
            cm_ev_r <= ({bus_ev.sof, bus_ev.bus_reset, bus_ev.resume, bus_ev.suspend})
                       | (cm_ev_r & ~(ev_clr ? ev_wmask[3:0] : 4'h0));
        end
    end

    // One flag per OUT endpoint
    for (genvar i = 1; i <= 3; i++) begin : g_out_ev
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                out_ev_r[i] <= 1'b0;
            end else if (out_ep_event[i]) begin
                out_ev_r[i] <= 1'b1;
            end else if (ev_clr && ev_wmask[4+i]) begin
                out_ev_r[i] <= 1'b0;
            end
        end
    end

    // Enable and index registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ie_r <= `UEP_OUT_IE_RST;
            cm_ie_r  <= `UEP_CM_IE_RST;
            index_r  <= 4'h0;
        end else if (wr_en) begin
            if (paddr == `UEP_ADDR_OUT_IE) begin
                out_ie_r <= pwdata[7:0] & `UEP_OUT_IE_MASK;
            end
            if (paddr == `UEP_ADDR_CM_IE) begin
                cm_ie_r <= pwdata[7:0] & `UEP_CM_IE_MASK;
            end
            if (paddr == `UEP_ADDR_INDEX) begin
                index_r <= pwdata[3:0];
            end
        end
    end

    // Interrupt request; endpoint zero is always enabled here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_irq <= 1'b0;
        end else begin
            usb_irq <= ep0_ev_r
                | (cm_ev_r[`UEP_CM_SOF] & cm_ie_r[`UEP_CM_SOF])
                | (cm_ev_r[`UEP_CM_RST] & cm_ie_r[`UEP_CM_RST])
                | (cm_ev_r[`UEP_CM_RSU] & cm_ie_r[`UEP_CM_RSU])
                | (cm_ev_r[`UEP_CM_SUS] & cm_ie_r[`UEP_CM_SUS])
                | (|(out_ev_r & out_ie_r[3:1]));
        end
    end

    // APB read data, one wait-free cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= rd_en;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (rd_en) begin
                case (paddr)
                    `UEP_ADDR_OUT_IE: prdata <= {24'h0, out_ie_r};
                    `UEP_ADDR_CM_IE:  prdata <= {24'h0, cm_ie_r};
                    `UEP_ADDR_INDEX:  prdata <= {28'h0, index_r};
                    `UEP_ADDR_E0CTL:  prdata <= e0_sel ? {27'h0, setup_end_flag_r, dend_r,
                                                   sent_stall_flag_r, txrdy_r, rxrdy_r}
                                                   : 32'h0000_0000;
                    `UEP_ADDR_EP_ZERO_BYTE_COUNT:  prdata <= e0_sel ? {25'h0, cnt_r} : 32'h0000_0000;
                    `UEP_ADDR_EVT:    prdata <= {24'h0, out_ev_r, ep0_ev_r, cm_ev_r};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule : uep_ctl

// ### uep_ctl_assertions.sv
// Port-level checks for the endpoint-zero control block.
// Assumes uep_pkg is compiled first and uep_defs.svh is on the include path.
`timescale 1ns/100ps
`include "uep_defs.svh"

module uep_ctl_checker
    import uep_pkg::*;
#(
    parameter int MAX_PKT = 64
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire uep_token_t  token,
    input wire uep_rxdone_t rx_done,
    input wire uep_hs_t     handshake,
    input wire logic        handshake_valid,
    input wire logic        usb_irq
);
    // Kind of the last token, so a packet end knows what it belongs to
    uep_tok_t last_kind_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_kind_r <= UEP_TOK_SOF;
        end else if (token.valid) begin
            last_kind_r <= token.kind;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_APB_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no pready after setup cycle");
    AST_BAD_CRC_SILENT: assert property (rx_done.valid && !rx_done.crc_ok && !token.valid
        |=> !handshake_valid) else $error("handshake for corrupted packet");
    AST_SETUP_ACK: assert property (rx_done.valid && rx_done.crc_ok
        && last_kind_r == UEP_TOK_SETUP && rx_done.len == `UEP_SETUP_LEN
        |=> handshake_valid && handshake == UEP_HS_ACK) else $error("setup not acked");
    AST_SETUP_BADLEN: assert property (rx_done.valid && rx_done.crc_ok
        && last_kind_r == UEP_TOK_SETUP && rx_done.len != `UEP_SETUP_LEN
        |=> !(handshake_valid && handshake == UEP_HS_ACK)) else $error("bad setup acked");
    AST_OVERSIZE_STALL: assert property (rx_done.valid && rx_done.crc_ok
        && last_kind_r == UEP_TOK_OUT && rx_done.len > MAX_PKT
        |=> handshake_valid && handshake == UEP_HS_STALL) else $error("oversize not stalled");
    AST_HS_CAUSE: assert property (handshake_valid |-> $past(token.valid) || $past(rx_done.valid))
        else $error("handshake without token or packet");
    AST_ACK_IRQ: assert property (handshake_valid && handshake == UEP_HS_ACK |=> usb_irq)
        else $error("no interrupt after ack");
    AST_STALL_IRQ: assert property (handshake_valid && handshake == UEP_HS_STALL
        |-> ##[1:2] usb_irq) else $error("no interrupt after stall");
endmodule : uep_ctl_checker

bind uep_ctl uep_ctl_checker #(.MAX_PKT(MAX_PKT)) i_uep_ctl_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .token(token), .rx_done(rx_done), .handshake(handshake),
    .handshake_valid(handshake_valid), .usb_irq(usb_irq));

// ### uep_host_model.sv
// Host stand-in: tokens, received-packet ends and host ACKs toward the block.
// Assumes its tasks are called just after a rising pclk edge.
`timescale 1ns/100ps

module uep_host_model
    import uep_pkg::*;
(
    input  wire logic   pclk,
    output uep_token_t  token,
    output uep_rxdone_t rx_done,
    output logic        tx_ack
);
    initial begin
        token   = '0;
        rx_done = '0;
        tx_ack  = 1'b0;
    end

    // Idle token drops valid and moves to endpoint 4'hf, idle packet end flips every field, so a stale value never reads as a live one
    task automatic send_token(input uep_tok_t kind);
        token <= '{1'b1, kind, 4'h0};
        @(posedge pclk);
        token <= '{1'b0, kind, 4'hf};
    endtask : send_token

    // Length and CRC result come from the caller; DATA1 defaults to zero
    task automatic send_data(input logic [6:0] len, input logic good,
                             input logic d1 = 1'b0);
        @(posedge pclk);
        rx_done <= '{1'b1, good, d1, len};
        @(posedge pclk);
        rx_done <= '{1'b0, ~good, ~d1, ~len};
    endtask : send_data

    task automatic send_ack();
        tx_ack <= 1'b1;
        @(posedge pclk);
        tx_ack <= 1'b0;
    endtask : send_ack
endmodule : uep_host_model

// ### testbench.sv
// Self-checking bench: APB register tasks plus host traffic through the model.
// Assumes uep_pkg, the design, the checker and the host model are compiled first.
`timescale 1ns/100ps
`include "uep_defs.svh"

module testbench;
    import uep_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic        tx_ack, handshake_valid, usb_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:1]  out_ep_event;
    uep_token_t  token;
    uep_rxdone_t rx_done;
    uep_busev_t  bus_ev;
    uep_hs_t     handshake, last_hs;
    int          err_count, checked, hs_cnt, n;

    uep_ctl #(.MAX_PKT(16)) i_uep_ctl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .token(token), .rx_done(rx_done),
        .tx_ack(tx_ack), .bus_ev(bus_ev), .out_ep_event(out_ep_event),
        .handshake(handshake), .handshake_valid(handshake_valid), .usb_irq(usb_irq));
    uep_host_model i_uep_host_model (.pclk(pclk), .token(token), .rx_done(rx_done),
        .tx_ack(tx_ack));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (handshake_valid === 1'b1) begin
            last_hs <= handshake;
            hs_cnt  <= hs_cnt + 1;
        end
    end

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        w = 0;
        do begin
            @(posedge pclk);
            w++;
        end while (pready !== 1'b1 && w < 50);
        if (w >= 50) err_count++;
        rd      = prdata;
        serr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rchk

    task automatic ev(input logic [3:0] b, input logic [3:1] o);
        bus_ev       <= b;
        out_ep_event <= o;
        @(posedge pclk);
        bus_ev       <= '0;
        out_ep_event <= '0;
        repeat (3) @(posedge pclk);
    endtask : ev

    task automatic pkt(input uep_tok_t k, input logic [6:0] len, input logic good,
                       input logic d1 = 1'b0);
        i_uep_host_model.send_token(k);
        i_uep_host_model.send_data(len, good, d1);
        repeat (3) @(posedge pclk);
    endtask : pkt

    // Setup, last IN packet loaded with data end, sent and acked by the host
    task automatic in_data();
        pkt(UEP_TOK_SETUP, 7'd8, 1'b1);
        apb(1'b1, `UEP_ADDR_E0CTL, 32'h40);
        apb(1'b1, `UEP_ADDR_E0CTL, 32'h0a);
        i_uep_host_model.send_token(UEP_TOK_IN);
        i_uep_host_model.send_ack();
        repeat (2) @(posedge pclk);
    endtask : in_data

    task automatic irq_is(input logic e);
        repeat (2) @(posedge pclk);
        check(32'(usb_irq), 32'(e));
    endtask : irq_is

    initial begin
        repeat (5000) @(posedge pclk);
        err_count++;
        final_report();
    end

    initial begin
        presetn      = 1'b0;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = '0;
        pwdata       = '0;
        bus_ev       = '0;
        out_ep_event = '0;
        last_hs      = UEP_HS_NONE;
        hs_cnt       = 0;
        err_count    = 0;
        checked      = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`UEP_ADDR_OUT_IE, 32'h0e);
        rchk(`UEP_ADDR_CM_IE, 32'h06);
        apb(1'b0, 12'hffc, 32'h0);
        check(32'(serr), 32'h1);
        apb(1'b1, `UEP_ADDR_OUT_IE, 32'hff);
        rchk(`UEP_ADDR_OUT_IE, 32'h0e);
        apb(1'b1, `UEP_ADDR_CM_IE, 32'hff);
        rchk(`UEP_ADDR_CM_IE, 32'h0f);
        $display("test registers done");
        apb(1'b1, `UEP_ADDR_OUT_IE, 32'h0);
        apb(1'b1, `UEP_ADDR_CM_IE, 32'h0);
        ev(4'hf, 3'h7);
        irq_is(1'b0);
        rchk(`UEP_ADDR_EVT, 32'hef);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, `UEP_ADDR_EVT, 32'hff);
            apb(1'b1, i < 4 ? `UEP_ADDR_CM_IE : `UEP_ADDR_OUT_IE,
                32'(i < 4 ? 1 << i : 1 << (i - 3)));
            irq_is(1'b0);
            ev(i < 4 ? 4'(1 << i) : 4'h0, i < 4 ? 3'h0 : 3'(1 << (i - 4)));
            irq_is(1'b1);
        end
        apb(1'b1, `UEP_ADDR_OUT_IE, 32'h0);
        apb(1'b1, `UEP_ADDR_EVT, 32'hff);
        irq_is(1'b0);
        $display("test enables done");
        apb(1'b1, `UEP_ADDR_INDEX, 32'h0);
        pkt(UEP_TOK_SETUP, 7'd8, 1'b1);
        check(32'(last_hs), 32'(UEP_HS_ACK));
        irq_is(1'b1);
        rchk(`UEP_ADDR_E0CTL, 32'h01);
        rchk(`UEP_ADDR_EP_ZERO_BYTE_COUNT, 32'h08);
        apb(1'b1, `UEP_ADDR_E0CTL, 32'h40);
        rchk(`UEP_ADDR_EP_ZERO_BYTE_COUNT, 32'h0);
        apb(1'b1, `UEP_ADDR_EVT, 32'hff);
        n = hs_cnt;
        pkt(UEP_TOK_SETUP, 7'd7, 1'b1);
        pkt(UEP_TOK_SETUP, 7'd8, 1'b0);
        check(32'(hs_cnt), 32'(n));
        irq_is(1'b0);
        rchk(`UEP_ADDR_E0CTL, 32'h0);
        $display("test setup done");
        i_uep_host_model.send_token(UEP_TOK_IN);
        irq_is(1'b0);
        check(32'(last_hs), 32'(UEP_HS_NAK));
        apb(1'b1, `UEP_ADDR_E0CTL, 32'h02);
        rchk(`UEP_ADDR_E0CTL, 32'h02);
        i_uep_host_model.send_token(UEP_TOK_IN);
        irq_is(1'b0);
        i_uep_host_model.send_ack();
        irq_is(1'b1);
        rchk(`UEP_ADDR_E0CTL, 32'h0);
        apb(1'b1, `UEP_ADDR_EVT, 32'hff);
        $display("test in done");
        apb(1'b1, `UEP_ADDR_E0CTL, 32'h20);
        irq_is(1'b1);
        rchk(`UEP_ADDR_E0CTL, 32'h04);
        apb(1'b1, `UEP_ADDR_E0CTL, 32'h0);
        pkt(UEP_TOK_OUT, 7'd17, 1'b1);
        check(32'(last_hs), 32'(UEP_HS_STALL));
        rchk(`UEP_ADDR_E0CTL, 32'h04);
        apb(1'b1, `UEP_ADDR_E0CTL, 32'h0);
        $display("test stall done");
        pkt(UEP_TOK_SETUP, 7'd8, 1'b1);
        apb(1'b1, `UEP_ADDR_E0CTL, 32'h40);
        pkt(UEP_TOK_OUT, 7'd16, 1'b1);
        apb(1'b1, `UEP_ADDR_E0CTL, 32'h40);
        i_uep_host_model.send_token(UEP_TOK_IN);
        repeat (3) @(posedge pclk);
        rchk(`UEP_ADDR_E0CTL, 32'h10);
        apb(1'b1, `UEP_ADDR_E0CTL, 32'h80);
        rchk(`UEP_ADDR_E0CTL, 32'h0);
        $display("test setup end done");
        in_data();
        i_uep_host_model.send_token(UEP_TOK_IN);
        repeat (2) @(posedge pclk);
        check(32'(last_hs), 32'(UEP_HS_STALL));
        rchk(`UEP_ADDR_E0CTL, 32'h04);
        apb(1'b1, `UEP_ADDR_E0CTL, 32'h0);
        in_data();
        apb(1'b1, `UEP_ADDR_EVT, 32'hff);
        n = hs_cnt;
        pkt(UEP_TOK_OUT, 7'd0, 1'b1, 1'b1);
        check(32'(hs_cnt), 32'(n + 1));
        check(32'(last_hs), 32'(UEP_HS_ACK));
        irq_is(1'b1);
        in_data();
        pkt(UEP_TOK_OUT, 7'd4, 1'b1, 1'b1);
        check(32'(last_hs), 32'(UEP_HS_STALL));
        rchk(`UEP_ADDR_E0CTL, 32'h04);
        apb(1'b1, `UEP_ADDR_E0CTL, 32'h0);
        $display("test control done");
        final_report();
    end
endmodule : testbench
